// ### core/cram_pkg.sv
package cram_pkg;
   // message tokens, control flag in bit 8
   localparam logic [7:0]  CT_CFG_WR   = 8'hC0;
   localparam logic [7:0]  CT_CFG_RD   = 8'hC1;
   localparam logic [7:0]  CT_PER_WR   = 8'h24;
   localparam logic [7:0]  CT_PER_RD   = 8'h25;
   localparam logic [7:0]  CT_ACK      = 8'h03;
   localparam logic [7:0]  CT_NACK     = 8'h04;
   localparam logic [7:0]  CT_END      = 8'h01;
   // destination low patterns
   localparam logic [15:0] TILE_LOW    = 16'hC20C;
   localparam logic [15:0] NODE_LOW    = 16'hC30C;
   localparam logic [7:0]  PERI_LOW    = 8'h02;
   localparam logic [7:0]  PS_LOW      = 8'h0B;
   localparam logic [7:0]  RET_QUIET   = 8'hFF;
   // byte counts, minus one where used as a last index
   localparam logic [2:0]  RET_LAST    = 3'h2;
   localparam logic [2:0]  CFG_REG_LAST = 3'h1;
   localparam logic [2:0]  WORD_BYTES  = 3'h4;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_RET   = 4'h1,
      ST_REG   = 4'h3,
      ST_SIZE  = 4'h2,
      ST_DATA  = 4'h6,
      ST_ENDT  = 4'h7,
      ST_ACC   = 4'h5,
      ST_RPLY  = 4'h4,
      ST_DRAIN = 4'hC
   } cram_state_t;

   typedef enum logic [2:0] {
      SP_NONE = 3'h0,
      SP_TILE = 3'h1,
      SP_NODE = 3'h2,
      SP_PERI = 3'h3,
      SP_PS   = 3'h4
   } cram_space_t;

   function automatic logic [31:0] ps_resource_id(input logic [7:0] num);
      return {16'h0000, num, PS_LOW};
   endfunction : ps_resource_id
endpackage : cram_pkg

// ### core/cram_reply_ser.sv
`timescale 1ns/10ps
module cram_reply_ser (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        start,
   input  wire logic        ok,
   input  wire logic [2:0]  nbytes,
   input  wire logic [31:0] data,
   input  wire logic        out_ready,
   output logic             out_valid,
   output logic [8:0]       out_tok
);
   logic [31:0] data_reg;
   logic [2:0]  cnt_reg;
   logic        end_reg;
   logic        out_valid_reg;
   logic [8:0]  out_tok_reg;
   logic        accept;
   logic [31:0] aligned;

   assign accept    = out_valid_reg && out_ready;
   // low bytes move to the top so bytes leave most significant first
   assign aligned   = data << {3'h4 - nbytes, 3'h0};
   assign out_valid = out_valid_reg;
   assign out_tok   = out_tok_reg;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         data_reg      <= 32'h0000_0000;
         cnt_reg       <= 3'h0;
         end_reg       <= 1'b0;
         out_valid_reg <= 1'b0;
         out_tok_reg   <= 9'h000;
      end
      else if (start)
      begin
         out_valid_reg <= 1'b1;
         out_tok_reg   <= {1'b1, ok ? cram_pkg::CT_ACK : cram_pkg::CT_NACK};
         cnt_reg       <= nbytes;
         data_reg      <= aligned;
         end_reg       <= 1'b1;
      end
      else if (accept)
      begin
         if (cnt_reg != 3'h0)
         begin
            out_tok_reg <= {1'b0, data_reg[31:24]};
            data_reg    <= {data_reg[23:0], 8'h00};
            cnt_reg     <= cnt_reg - 3'h1;
         end
         else if (end_reg)
         begin
            out_tok_reg <= {1'b1, cram_pkg::CT_END};
            end_reg     <= 1'b0;
         end
         else
         begin
            out_valid_reg <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_end_closes_reply: assert property (
      out_valid_reg && out_ready && cnt_reg == 3'h0 && end_reg
      |=> out_valid_reg && out_tok_reg == {1'b1, cram_pkg::CT_END})
      else $error("reply not closed by end token");

   a_bytes_msb_first: assert property (
      accept && cnt_reg != 3'h0
      |=> out_tok_reg == {1'b0, $past(data_reg[31:24])})
      else $error("reply byte out of order");
endmodule : cram_reply_ser

// ### core/cram_msg_engine.sv
// Contract
// - write with return low byte all ones: no reply
// - multi-byte fields go most significant first
// - status read and write move whole words
// - config write: 192, return, reg, data, 1
// - config read: 193, return, reg, 1
// - peripheral: 36, return, reg, size, data, 1; 37, return, reg, size, 1
// - write reply: 3,1 success; 4,1 failure
// - config read reply: 3, word, 1
// - peripheral read reply: 3, size bytes, 1
`timescale 1ns/10ps
module cram_msg_engine #(
   parameter int MAX_PER_BYTES = 4
) (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic          in_valid,
   input  wire logic [8:0]    in_tok,
   input  wire logic [31:0]   in_dest,
   output logic               in_ready,
   output logic               out_valid,
   output logic [8:0]         out_tok,
   output logic [23:0]        out_ret,
   input  wire logic          out_ready,
   output logic               reg_req,
   output cram_pkg::cram_space_t reg_space,
   output logic               reg_wr,
   output logic [15:0]        reg_addr,
   output logic [7:0]         reg_periph,
   output logic [2:0]         reg_size,
   output logic [31:0]        reg_wdata,
   input  wire logic          reg_ack,
   input  wire logic          reg_ok,
   input  wire logic [31:0]   reg_rdata,
   input  wire logic          ps_req,
   input  wire logic          ps_wr,
   input  wire logic [31:0]   ps_resid,
   input  wire logic [31:0]   ps_wdata,
   output logic               ps_done,
   output logic               ps_ok,
   output logic [31:0]        ps_rdata
);
   if (MAX_PER_BYTES < 1 || MAX_PER_BYTES > 4)
   begin : g_bad_width
      $error("MAX_PER_BYTES must lie in 1..4");
   end

   localparam logic [7:0] MAXB = 8'(MAX_PER_BYTES);

   cram_pkg::cram_state_t state_reg, state_next;
   cram_pkg::cram_space_t space_reg, space_next;
   logic [23:0] ret_reg, ret_next, out_ret_reg;
   logic [15:0] addr_reg, addr_next;
   logic [31:0] wdata_reg, wdata_next, ps_rdata_reg;
   logic [7:0]  periph_reg, periph_next;
   logic [2:0]  cnt_reg, cnt_next, nb_reg, nb_next;
   logic        wr_reg, wr_next, err_reg, err_next, quiet_reg, quiet_next;
   logic        ps_mode_reg, ps_mode_next, reg_req_reg, in_ready_reg;
   logic        ps_done_reg, ps_ok_reg;

   logic       take, is_ctl, is_end, op_cfg, op_per, hdr_ok, size_bad;
   logic       dest_tile, dest_node, dest_peri, finish, res_ok, quiet_now;
   logic       ser_start, ps_take, ser_valid;
   logic [7:0] tb;
   logic [2:0] ser_nb;

   assign take      = in_valid && in_ready_reg;
   assign is_ctl    = in_tok[8];
   assign tb        = in_tok[7:0];
   assign is_end    = is_ctl && tb == cram_pkg::CT_END;
   assign dest_tile = in_dest[15:0] == cram_pkg::TILE_LOW;
   assign dest_node = in_dest[15:0] == cram_pkg::NODE_LOW;
   assign dest_peri = in_dest[7:0] == cram_pkg::PERI_LOW;
   assign op_cfg    = is_ctl && (tb == cram_pkg::CT_CFG_WR || tb == cram_pkg::CT_CFG_RD);
   assign op_per    = is_ctl && (tb == cram_pkg::CT_PER_WR || tb == cram_pkg::CT_PER_RD);
   assign hdr_ok    = (op_cfg && (dest_tile || dest_node)) || (op_per && dest_peri);
   assign size_bad  = tb == 8'h00 || tb > MAXB;
   assign finish    = state_reg == cram_pkg::ST_ACC && (err_reg || reg_ack);
   assign res_ok    = !err_reg && reg_ok;
   assign quiet_now = quiet_reg || (wr_reg && ret_reg[7:0] == cram_pkg::RET_QUIET);
   assign ser_start = finish && !ps_mode_reg && !quiet_now;
   assign ser_nb    = (res_ok && !wr_reg) ? nb_reg : 3'h0;
   // tokens win over a status access; the access waits for idle
   assign ps_take   = state_reg == cram_pkg::ST_IDLE && !take && ps_req;

   always_comb
   begin
      state_next   = state_reg;
      space_next   = space_reg;
      ret_next     = ret_reg;
      addr_next    = addr_reg;
      wdata_next   = wdata_reg;
      periph_next  = periph_reg;
      cnt_next     = cnt_reg;
      nb_next      = nb_reg;
      wr_next      = wr_reg;
      err_next     = err_reg;
      quiet_next   = quiet_reg;
      ps_mode_next = ps_mode_reg;
      case (state_reg)
         cram_pkg::ST_IDLE:
         begin
            cnt_next     = 3'h0;
            err_next     = 1'b0;
            quiet_next   = 1'b0;
            ps_mode_next = 1'b0;
            addr_next    = 16'h0000;
            wdata_next   = 32'h0000_0000;
            if (take && hdr_ok)
            begin
               state_next  = cram_pkg::ST_RET;
               wr_next     = tb == cram_pkg::CT_CFG_WR || tb == cram_pkg::CT_PER_WR;
               space_next  = op_per ? cram_pkg::SP_PERI :
                             dest_tile ? cram_pkg::SP_TILE : cram_pkg::SP_NODE;
               periph_next = in_dest[15:8];
               nb_next     = cram_pkg::WORD_BYTES;
            end
            else if (take && !is_end)
            begin
               // no return address known yet, so it can only be dropped
               state_next = cram_pkg::ST_DRAIN;
               err_next   = 1'b1;
               quiet_next = 1'b1;
            end
            else if (ps_take)
            begin
               state_next   = cram_pkg::ST_ACC;
               ps_mode_next = 1'b1;
               wr_next      = ps_wr;
               space_next   = cram_pkg::SP_PS;
               addr_next    = {8'h00, ps_resid[15:8]};
               wdata_next   = ps_wdata;
               nb_next      = cram_pkg::WORD_BYTES;
               err_next     = ps_resid != cram_pkg::ps_resource_id(ps_resid[15:8]);
            end
         end
         cram_pkg::ST_RET:
            if (take && is_ctl)
            begin
               state_next = cram_pkg::ST_DRAIN;
               err_next   = 1'b1;
               quiet_next = 1'b1;
            end
            else if (take)
            begin
               ret_next = {ret_reg[15:0], tb};
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == cram_pkg::RET_LAST)
               begin
                  state_next = cram_pkg::ST_REG;
                  cnt_next   = 3'h0;
               end
            end
         cram_pkg::ST_REG:
            if (take && is_ctl)
            begin
               state_next = cram_pkg::ST_DRAIN;
               err_next   = 1'b1;
            end
            else if (take)
            begin
               addr_next = {addr_reg[7:0], tb};
               cnt_next  = cnt_reg + 3'h1;
               if (space_reg == cram_pkg::SP_PERI)
                  state_next = cram_pkg::ST_SIZE;
               else if (cnt_reg == cram_pkg::CFG_REG_LAST)
               begin
                  state_next = wr_reg ? cram_pkg::ST_DATA : cram_pkg::ST_ENDT;
                  cnt_next   = 3'h0;
               end
            end
         cram_pkg::ST_SIZE:
            if (take && is_ctl)
            begin
               state_next = cram_pkg::ST_DRAIN;
               err_next   = 1'b1;
            end
            else if (take)
            begin
               nb_next  = tb[2:0];
               cnt_next = 3'h0;
               err_next = size_bad;
               // a bad size leaves the data length unknown: skip to the end token
               if (wr_reg)
                  state_next = size_bad ? cram_pkg::ST_DRAIN : cram_pkg::ST_DATA;
               else
                  state_next = cram_pkg::ST_ENDT;
            end
         cram_pkg::ST_DATA:
            if (take && is_ctl)
            begin
               state_next = cram_pkg::ST_DRAIN;
               err_next   = 1'b1;
            end
            else if (take)
            begin
               wdata_next = {wdata_reg[23:0], tb};
               cnt_next   = cnt_reg + 3'h1;
               if (cnt_reg == nb_reg - 3'h1)
                  state_next = cram_pkg::ST_ENDT;
            end
         cram_pkg::ST_ENDT:
            if (take)
            begin
               state_next = is_end ? cram_pkg::ST_ACC : cram_pkg::ST_DRAIN;
               err_next   = err_reg || !is_end;
            end
         cram_pkg::ST_DRAIN:
            if (take && is_end)
               state_next = cram_pkg::ST_ACC;
         cram_pkg::ST_ACC:
            if (finish)
               state_next = ser_start ? cram_pkg::ST_RPLY : cram_pkg::ST_IDLE;
         cram_pkg::ST_RPLY:
            if (!ser_valid)
               state_next = cram_pkg::ST_IDLE;
         default:
            state_next = cram_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_reg    <= cram_pkg::ST_IDLE;
         space_reg    <= cram_pkg::SP_NONE;
         ret_reg      <= 24'h00_0000;
         addr_reg     <= 16'h0000;
         wdata_reg    <= 32'h0000_0000;
         periph_reg   <= 8'h00;
         cnt_reg      <= 3'h0;
         nb_reg       <= 3'h0;
         wr_reg       <= 1'b0;
         err_reg      <= 1'b0;
         quiet_reg    <= 1'b0;
         ps_mode_reg  <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         space_reg    <= space_next;
         ret_reg      <= ret_next;
         addr_reg     <= addr_next;
         wdata_reg    <= wdata_next;
         periph_reg   <= periph_next;
         cnt_reg      <= cnt_next;
         nb_reg       <= nb_next;
         wr_reg       <= wr_next;
         err_reg      <= err_next;
         quiet_reg    <= quiet_next;
         ps_mode_reg  <= ps_mode_next;
      end
   end

   // request held until acknowledged; input stalls meanwhile
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         reg_req_reg  <= 1'b0;
         in_ready_reg <= 1'b0;
         out_ret_reg  <= 24'h00_0000;
         ps_done_reg  <= 1'b0;
         ps_ok_reg    <= 1'b0;
         ps_rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         reg_req_reg  <= state_next == cram_pkg::ST_ACC && !err_next && !finish;
         in_ready_reg <= state_next != cram_pkg::ST_ACC && state_next != cram_pkg::ST_RPLY;
         out_ret_reg  <= ser_start ? ret_reg : out_ret_reg;
         ps_done_reg  <= finish && ps_mode_reg;
         ps_ok_reg    <= finish && ps_mode_reg ? res_ok : ps_ok_reg;
         ps_rdata_reg <= finish && ps_mode_reg ? reg_rdata : ps_rdata_reg;
      end
   end

   cram_reply_ser u_ser (
      .clk       (clk),
      .rstn      (rstn),
      .start     (ser_start),
      .ok        (res_ok),
      .nbytes    (ser_nb),
      .data      (reg_rdata),
      .out_ready (out_ready),
      .out_valid (ser_valid),
      .out_tok   (out_tok)
   );

   assign in_ready   = in_ready_reg;
   assign out_valid  = ser_valid;
   assign out_ret    = out_ret_reg;
   assign reg_req    = reg_req_reg;
   assign reg_space  = space_reg;
   assign reg_wr     = wr_reg;
   assign reg_addr   = addr_reg;
   assign reg_periph = periph_reg;
   assign reg_size   = nb_reg;
   assign reg_wdata  = wdata_reg;
   assign ps_done    = ps_done_reg;
   assign ps_ok      = ps_ok_reg;
   assign ps_rdata   = ps_rdata_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_hdr_take;
      state_reg == cram_pkg::ST_IDLE && take && hdr_ok;
   endsequence
   sequence s_ps_take;
      ps_take;
   endsequence

   a_header_opens: assert property (s_hdr_take |=> state_reg == cram_pkg::ST_RET)
      else $error("header did not open a request");

   a_return_three: assert property (
      state_reg == cram_pkg::ST_RET && take && !is_ctl && cnt_reg == 3'h2
      |=> state_reg == cram_pkg::ST_REG && ret_reg[7:0] == $past(tb))
      else $error("return field not three bytes");

   a_quiet_write: assert property (
      finish && wr_reg && ret_reg[7:0] == 8'hFF
      |-> !ser_start ##1 state_reg == cram_pkg::ST_IDLE && !ser_valid)
      else $error("reply sent for quiet write");

   a_single_request: assert property (
      reg_req_reg |-> state_reg == cram_pkg::ST_ACC && !in_ready_reg)
      else $error("request overlaps input");

   a_ps_word: assert property (
      s_ps_take |=> wdata_reg == $past(ps_wdata) && nb_reg == 3'h4)
      else $error("status access not a whole word");

   a_ps_resid: assert property (
      s_ps_take ##0 ps_resid == {16'h0000, ps_resid[15:8], 8'h0B}
      |=> reg_req_reg && addr_reg == {8'h00, $past(ps_resid[15:8])})
      else $error("status number not decoded");

   a_fail_reply: assert property (
      ser_start && !res_ok
      |=> ser_valid && out_tok == {1'b1, 8'h04} && state_reg == cram_pkg::ST_RPLY)
      else $error("failure reply head wrong");

   a_read_word: assert property (
      ser_start && res_ok && !wr_reg && space_reg != cram_pkg::SP_PERI
      |-> ser_nb == 3'h4 ##1 out_tok == {1'b1, 8'h03})
      else $error("config read reply not a word");
endmodule : cram_msg_engine

// ### sim/cram_reg_model.sv
`timescale 1ns/10ps
// register-side responder: answers reg_req after lat idle cycles
module cram_reg_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        reg_req,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic [1:0]  lat,
   input  wire logic        fail,
   output logic             reg_ack,
   output logic             reg_ok,
   output logic [31:0]      reg_rdata
);
   logic [31:0] mem [16];
   logic [1:0]  wait_reg;

   // outside the ack cycle ok and data toggle, so a stale value read there shows up wrong
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         reg_ack   <= 1'b0;
         reg_ok    <= 1'b0;
         reg_rdata <= 32'h5A5A5A5A;
         wait_reg  <= 2'h0;
      end
      else if (reg_req && !reg_ack && wait_reg == lat)
      begin
         reg_ack   <= 1'b1;
         reg_ok    <= !fail;
         reg_rdata <= mem[reg_addr[3:0]];
         wait_reg  <= 2'h0;
         if (reg_wr && !fail) mem[reg_addr[3:0]] <= reg_wdata;
      end
      else
      begin
         reg_ack   <= 1'b0;
         reg_ok    <= ~reg_ok;
         reg_rdata <= ~reg_rdata;
         if (reg_req && !reg_ack) wait_reg <= wait_reg + 2'h1;
      end
   end
endmodule : cram_reg_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic clk, rstn, in_valid, in_ready, out_valid, out_ready;
   logic [8:0] in_tok, out_tok;
   logic [31:0] in_dest, reg_wdata, reg_rdata, ps_resid, ps_wdata, ps_rdata;
   logic [23:0] out_ret;
   logic reg_req, reg_wr, reg_ack, reg_ok, ps_req, ps_wr, ps_done, ps_ok, fail;
   cram_pkg::cram_space_t reg_space;
   logic [15:0] reg_addr;
   logic [7:0]  reg_periph;
   logic [2:0]  reg_size;
   logic [1:0]  lat;
   logic [8:0]  rq [$];
   logic [23:0] ret_seen;
   logic        ps_seen, ps_ok_s;
   logic [31:0] ps_rd_s;
   logic [2:0]  sp_seen, sz_seen;
   logic [7:0]  pid_seen;
   int          err_count, checks_done;

   cram_msg_engine #(.MAX_PER_BYTES(4)) cram_msg_engine_inst (
      .clk(clk), .rstn(rstn), .in_valid(in_valid), .in_tok(in_tok), .in_dest(in_dest),
      .in_ready(in_ready), .out_valid(out_valid), .out_tok(out_tok), .out_ret(out_ret),
      .out_ready(out_ready), .reg_req(reg_req), .reg_space(reg_space), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_periph(reg_periph), .reg_size(reg_size),
      .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_ok(reg_ok), .reg_rdata(reg_rdata),
      .ps_req(ps_req), .ps_wr(ps_wr), .ps_resid(ps_resid), .ps_wdata(ps_wdata),
      .ps_done(ps_done), .ps_ok(ps_ok), .ps_rdata(ps_rdata));

   cram_reg_model cram_reg_model_inst (
      .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .lat(lat), .fail(fail), .reg_ack(reg_ack),
      .reg_ok(reg_ok), .reg_rdata(reg_rdata));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // reply and status monitor, sampled at the edge before design updates land
   always @(posedge clk)
   begin
      if (out_valid && out_ready) rq.push_back(out_tok);
      if (out_valid && out_ready) ret_seen = out_ret;
      if (ps_done) ps_seen = 1'b1;
      if (ps_done) ps_ok_s = ps_ok;
      if (ps_done) ps_rd_s = ps_rdata;
      if (reg_req) sp_seen = reg_space;
      if (reg_req) sz_seen = reg_size;
      if (reg_req) pid_seen = reg_periph;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic send_tok(input logic [8:0] t);
      int n;
      in_valid = 1'b1;
      in_tok   = t;
      n = 0;
      while (in_ready !== 1'b1 && n < 200)
      begin
         @(posedge clk) #1;
         n++;
      end
      @(posedge clk) #1;
   endtask : send_tok

   // ret, register and data fields are cut into bytes most significant first
   task automatic send_msg(input logic [31:0] dest, input logic [7:0] hd,
                           input logic [23:0] ret, input logic [15:0] ra, input int nra,
                           input int sz, input int nd, input logic [31:0] d);
      in_dest = dest;
      send_tok({1'b1, hd});
      for (int i = 2; i >= 0; i--) send_tok({1'b0, ret[i*8+:8]});
      for (int i = nra - 1; i >= 0; i--) send_tok({1'b0, ra[i*8+:8]});
      if (sz >= 0) send_tok({1'b0, 8'(sz)});
      for (int i = nd - 1; i >= 0; i--) send_tok({1'b0, d[i*8+:8]});
      send_tok({1'b1, cram_pkg::CT_END});
      in_valid = 1'b0;
      in_tok   = ~in_tok;
   endtask : send_msg

   task automatic expect_reply(input logic [8:0] e [$]);
      int n;
      n = 0;
      while (rq.size() < e.size() && n < 300)
      begin
         @(posedge clk) #1;
         n++;
      end
      repeat (4) @(posedge clk) #1;
      chk("reply_len", 32'(rq.size()), 32'(e.size()));
      foreach (e[i]) chk("reply_tok", 32'(rq[i]), 32'(e[i]));
      rq.delete();
   endtask : expect_reply

   task automatic t_cfg;
      lat = 2'h3;
      send_msg(32'h0001C20C, cram_pkg::CT_CFG_WR, 24'h0A0B0C, 16'h0005, 2, -1, 4,
               32'h12345678);
      expect_reply('{9'h103, 9'h101});
      chk("out_ret", 32'(ret_seen), 32'h000A0B0C);
      chk("reg_space", 32'(sp_seen), 32'(cram_pkg::SP_TILE));
      lat = 2'h0;
      send_msg(32'h0002C30C, cram_pkg::CT_CFG_RD, 24'h0A0B0D, 16'h0005, 2, -1, 0, 32'h0);
      expect_reply('{9'h103, 9'h012, 9'h034, 9'h056, 9'h078, 9'h101});
      chk("reg_space", 32'(sp_seen), 32'(cram_pkg::SP_NODE));
   endtask : t_cfg

   task automatic t_quiet;
      send_msg(32'h0001C20C, cram_pkg::CT_CFG_WR, 24'h0A0BFF, 16'h0006, 2, -1, 4,
               32'h89ABCDEF);
      repeat (30) @(posedge clk) #1;
      chk("quiet_cnt", 32'(rq.size()), 32'h0);
      send_msg(32'h0001C20C, cram_pkg::CT_CFG_RD, 24'h0A0B0C, 16'h0006, 2, -1, 0, 32'h0);
      expect_reply('{9'h103, 9'h089, 9'h0AB, 9'h0CD, 9'h0EF, 9'h101});
   endtask : t_quiet

   task automatic t_peri;
      send_msg(32'h00013702, cram_pkg::CT_PER_WR, 24'h0A0B0C, 16'h0009, 1, 2, 2,
               32'h0000ABCD);
      expect_reply('{9'h103, 9'h101});
      chk("reg_space", 32'(sp_seen), 32'(cram_pkg::SP_PERI));
      chk("reg_periph", 32'(pid_seen), 32'h00000037);
      chk("reg_size", 32'(sz_seen), 32'h00000002);
      send_msg(32'h00013702, cram_pkg::CT_PER_RD, 24'h0A0B0C, 16'h0009, 1, 2, 0, 32'h0);
      expect_reply('{9'h103, 9'h0AB, 9'h0CD, 9'h101});
      send_msg(32'h00013702, cram_pkg::CT_PER_RD, 24'h0A0B0C, 16'h0009, 1, 0, 0, 32'h0);
      expect_reply('{9'h104, 9'h101});
   endtask : t_peri

   task automatic t_fail;
      fail = 1'b1;
      send_msg(32'h0001C20C, cram_pkg::CT_CFG_WR, 24'h0A0B0C, 16'h0001, 2, -1, 4, 32'h1);
      expect_reply('{9'h104, 9'h101});
      send_msg(32'h0002C30C, cram_pkg::CT_CFG_RD, 24'h0A0B0C, 16'h0001, 2, -1, 0, 32'h0);
      expect_reply('{9'h104, 9'h101});
      fail = 1'b0;
   endtask : t_fail

   // refused messages: foreign header dropped silently, broken fields failed
   task automatic t_bad;
      send_msg(32'h00013702, cram_pkg::CT_CFG_RD, 24'h0A0B0C, 16'h0005, 2, -1, 0, 32'h0);
      repeat (20) @(posedge clk) #1;
      chk("drop_cnt", 32'(rq.size()), 32'h0);
      send_msg(32'h00013702, cram_pkg::CT_PER_WR, 24'h0A0B0C, 16'h0009, 1, 5, 0, 32'h0);
      expect_reply('{9'h104, 9'h101});
      in_dest = 32'h0001C20C;
      send_tok({1'b1, cram_pkg::CT_CFG_RD});
      for (int i = 2; i >= 0; i--) send_tok({1'b0, 8'h0A});
      // control token where the register number belongs, then the real end
      send_tok({1'b1, cram_pkg::CT_END});
      send_tok({1'b1, cram_pkg::CT_END});
      in_valid = 1'b0;
      expect_reply('{9'h104, 9'h101});
   endtask : t_bad

   // a held reply keeps the engine closed to the next request
   task automatic t_stall;
      out_ready = 1'b0;
      send_msg(32'h0001C20C, cram_pkg::CT_CFG_RD, 24'h0A0B0C, 16'h0005, 2, -1, 0, 32'h0);
      repeat (10) @(posedge clk) #1;
      chk("stall_valid", 32'(out_valid), 32'h1);
      chk("stall_tok", 32'(out_tok), 32'h103);
      chk("stall_ready", 32'(in_ready), 32'h0);
      out_ready = 1'b1;
      expect_reply('{9'h103, 9'h012, 9'h034, 9'h056, 9'h078, 9'h101});
   endtask : t_stall

   task automatic ps_op(input logic wr, input logic [31:0] id, input logic [31:0] d);
      int n;
      n = 0;
      while (in_ready !== 1'b1 && n < 100)
      begin
         @(posedge clk) #1;
         n++;
      end
      ps_seen  = 1'b0;
      ps_req   = 1'b1;
      ps_wr    = wr;
      ps_resid = id;
      ps_wdata = d;
      @(posedge clk) #1;
      ps_req = 1'b0;
      ps_resid = ~ps_resid;
      for (n = 0; n < 50 && !ps_seen; n++) @(posedge clk) #1;
      chk("ps_done", 32'(ps_seen), 32'h1);
   endtask : ps_op

   task automatic t_ps;
      ps_op(1'b1, {16'h0000, 8'h07, 8'h0B}, 32'hCAFEF00D);
      chk("ps_wr_ok", 32'(ps_ok_s), 32'h1);
      chk("ps_space", 32'(sp_seen), 32'(cram_pkg::SP_PS));
      chk("ps_size", 32'(sz_seen), 32'h00000004);
      ps_op(1'b0, {16'h0000, 8'h07, 8'h0B}, 32'h0);
      chk("ps_rdata", ps_rd_s, 32'hCAFEF00D);
      ps_op(1'b0, {16'h0001, 8'h07, 8'h0B}, 32'h0);
      chk("ps_bad_ok", 32'(ps_ok_s), 32'h0);
   endtask : t_ps

   task automatic wrap_up;
      $display("checks_done %0d err_count %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      #40000;
      err_count++;
      wrap_up();
   end

   initial
   begin
      err_count = 0;
      checks_done = 0;
      rstn = 1'b0;
      in_valid = 1'b0;
      in_tok = 9'h000;
      in_dest = 32'h0;
      out_ready = 1'b1;
      ps_req = 1'b0;
      ps_wr = 1'b0;
      ps_resid = 32'h0;
      ps_wdata = 32'h0;
      fail = 1'b0;
      lat = 2'h1;
      ps_seen = 1'b0;
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      t_cfg();
      t_quiet();
      t_peri();
      t_fail();
      t_bad();
      t_stall();
      t_ps();
      wrap_up();
   end
endmodule : tb_top
